// ==== hdl/line_cam_pkg.sv ====
/*
 * Constants shared by the acquisition command handler: command codes, reply bytes,
 * frame geometry and memory sizing.
 * Assumes nothing of its surroundings.
 */
package line_cam_pkg;
   localparam logic [7:0] CMD_STORED = 8'hc6;
   localparam logic [7:0] CMD_STREAM = 8'hc7;
   localparam logic [7:0] CMD_STOP = 8'hc8;
   localparam logic [7:0] CMD_SET_COUNT = 8'hc2;
   localparam logic [7:0] CMD_SET_DUMMY = 8'hc9;
   localparam logic [7:0] CMD_SERIAL = 8'hd1;
   localparam logic [7:0] CMD_SIGNATURE = 8'hd2;
   localparam logic [7:0] REPLY_ACK = 8'h06;
   localparam logic [7:0] REPLY_NACK = 8'h15;
   localparam logic [12:0] MAX_FRAMES = 13'h11f7;
   localparam logic [12:0] MAX_FRAMES_DUMMY = 13'h11bd;
   localparam logic [12:0] DEFAULT_FRAMES = 13'h0001;
   localparam logic [11:0] PIX_ACTIVE = 12'he40;
   localparam logic [11:0] PIX_DUMMY = 12'he6e;
   localparam logic [2:0] QUERY_BYTES_LAST = 3'h7;
   localparam logic [1:0] COUNT_BYTES_LAST = 2'h3;
endpackage : line_cam_pkg

// ==== hdl/reply_serializer.sv ====
/*
 * Splits 16-bit pixel words into two reply bytes, high byte first.
 * Assumes a ready/valid byte sink on one clock with the handler.
 */
`timescale 1ns/10ps
module reply_serializer (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_word_valid,
   input wire logic [15:0] i_word,
   output logic o_word_ready,
   output logic o_byte_valid,
   output logic [7:0] o_byte,
   input wire logic i_byte_ready
);
   typedef struct packed {
      logic [7:0] low;
      logic have_low;
      logic valid;
      logic [7:0] data;
   } ser_s;
   ser_s cur;
   ser_s next_cur;

   always_comb begin
      next_cur = cur;
      if (cur.valid && i_byte_ready) begin
         next_cur.valid = 1'b0;
      end
      if (!next_cur.valid && cur.have_low) begin
         next_cur.valid = 1'b1;
         next_cur.data = cur.low;
         next_cur.have_low = 1'b0;
      end else if (!next_cur.valid && i_word_valid) begin
         next_cur.valid = 1'b1;
         next_cur.data = i_word[15:8];
         next_cur.low = i_word[7:0];
         next_cur.have_low = 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign o_word_ready = (!cur.valid || i_byte_ready) && !cur.have_low;
   assign o_byte_valid = cur.valid;
   assign o_byte = cur.data;

   property msb_then_lsb;
      @(posedge i_clk) disable iff (!i_nrst)
         (i_word_valid && o_word_ready) |=> (o_byte == $past(i_word[15:8]) && cur.have_low);
   endproperty
   msb_first_a: assert property (msb_then_lsb) else $error("high byte not sent first");
endmodule : reply_serializer

// ==== hdl/line_camera_acquisition_cmds.sv ====
/*
 * Acquisition command handler: decodes host command bytes, runs stored capture and
 * streaming through a frame memory, and answers queries.
 * Assumes command bytes arrive as a ready/valid byte stream from the USB bridge logic,
 * reply bytes leave the same way, and sensor pixels arrive as a word stream per
 * triggered frame with a frame-start pulse on the same clock.
 */
`timescale 1ns/10ps
// Overview of operation
// - 0xc6 with no data starts stored capture.
// - stored frames kept in onboard memory, up to 4599 frames.
// - stored capture stops by itself after the preset frame count.
// - after stored capture, all captured frames are sent at once.
// - no further command is taken until stored data is fully sent.
// - frames hold 3648 pixels, or 3694 with dummy pixels.
// - each pixel sent as two bytes, high byte first.
// - 0xc7 with no data starts streaming; frames sent when available.
// - streaming ignores frame count and runs until stop.
// - after stop, one more frame is captured, then capture ends.
// - streaming uses the frame memory as a fifo.
// - after streaming stops, buffered frames drain to the host.
// - buffer overflow lights error and aborts streaming until reset.
// - 0xc8 with no data stops streaming; reply is remaining data.
// - 0xd1 returns 64-bit serial number, msb first.
// - 0xd2 returns 64-bit signature, msb first.
// - command byte then its data bytes, msb first.
// - unknown command or out-of-range data answered with 0x15.
// - 0xc2 sets frame count, capped at 4599 or 4541 with dummies.
// - 0xc9 sets dummy pixel inclusion, off by default.
module line_camera_acquisition_cmds #(
   parameter int ADDR_W = 24,
   parameter logic [63:0] SERIAL_NUMBER = 64'h0000_0000_0000_0001, // arbitrary value
   parameter logic [63:0] SIGNATURE = 64'h0000_0000_0000_0002 // arbitrary value
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_cmd_valid,
   input wire logic [7:0] i_cmd_byte,
   output logic o_cmd_ready,
   output logic o_reply_valid,
   output logic [7:0] o_reply_byte,
   input wire logic i_reply_ready,
   input wire logic i_frame_start,
   input wire logic i_pix_valid,
   input wire logic [15:0] i_pix,
   output logic o_capture_active,
   output logic o_error
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ARGS = 3'b001,
      ST_STORE = 3'b010,
      ST_DRAIN = 3'b011,
      ST_STREAM = 3'b100,
      ST_QUERY = 3'b101,
      ST_BYTE = 3'b110,
      ST_FAULT = 3'b111
   } state_e;

   typedef struct packed {
      state_e st;
      logic [7:0] cmd;
      logic [31:0] arg;
      logic [1:0] arg_cnt;
      logic [12:0] frames_set;
      logic dummy_en;
      logic [12:0] frames_done;
      logic [11:0] pix_cnt;
      logic in_frame;
      logic stop_req;
      logic capturing;
      logic [ADDR_W-1:0] wr_ptr;
      logic [ADDR_W-1:0] rd_ptr;
      logic [ADDR_W:0] level;
      logic [63:0] qshift;
      logic [2:0] qcnt;
      logic [7:0] one_byte;
      logic cmd_ready;
      logic error;
      logic stop_frame;
      logic out_valid;
      logic [7:0] out_byte;
   } ctl_s;

   ctl_s cur;
   ctl_s next_cur;

   logic [15:0] mem [0:(1<<ADDR_W)-1];
   logic [15:0] rd_word;
   logic rd_valid;
   logic word_ready;
   logic ser_valid;
   logic [7:0] ser_byte;
   logic wr_en;
   logic pop;
   logic stored_valid;

   function automatic logic [11:0] frame_len(input logic dummy);
      frame_len = dummy ? line_cam_pkg::PIX_DUMMY : line_cam_pkg::PIX_ACTIVE;
   endfunction : frame_len

   localparam logic [ADDR_W:0] MEM_WORDS = (ADDR_W+1)'(1 << ADDR_W);

   logic out_take;
   logic byte_out_valid;
   logic byte_take;
   logic [7:0] byte_out;

   assign wr_en = cur.capturing && cur.in_frame && i_pix_valid && cur.level != MEM_WORDS;
   assign stored_valid = (cur.st == ST_DRAIN || cur.st == ST_STREAM) && cur.level != '0;
   assign pop = stored_valid && word_ready;
   assign rd_valid = stored_valid;
   // one registered reply byte; pixel bytes win over query and ack bytes
   assign out_take = !cur.out_valid || i_reply_ready;
   assign byte_out_valid = (cur.st == ST_QUERY || cur.st == ST_BYTE) && !ser_valid;
   assign byte_take = byte_out_valid && out_take;
   assign byte_out = cur.st == ST_QUERY ? cur.qshift[63:56] : cur.one_byte;

   always_comb begin
      next_cur = cur;
      next_cur.cmd_ready = 1'b0;
      if (out_take) begin
         next_cur.out_valid = ser_valid || byte_out_valid;
         next_cur.out_byte = ser_valid ? ser_byte : byte_out;
      end
      // capture path: frame counting, fifo write
      if (cur.capturing && i_frame_start && !cur.in_frame) begin
         next_cur.in_frame = 1'b1;
         next_cur.pix_cnt = '0;
         next_cur.stop_frame = cur.stop_req;
      end
      if (cur.capturing && cur.in_frame && i_pix_valid) begin
         if (cur.level == MEM_WORDS) begin
            next_cur.error = 1'b1;
            next_cur.capturing = 1'b0;
            next_cur.st = ST_FAULT;
         end else begin
            next_cur.wr_ptr = cur.wr_ptr + 1'b1;
            if (cur.pix_cnt == frame_len(cur.dummy_en) - 12'h001) begin
               next_cur.in_frame = 1'b0;
               next_cur.frames_done = cur.frames_done + 13'h0001;
               if (cur.st == ST_STORE && cur.frames_done + 13'h0001 == cur.frames_set) begin
                  next_cur.capturing = 1'b0;
                  next_cur.st = ST_DRAIN;
               end
               if (cur.st == ST_STREAM && cur.stop_frame) begin
                  next_cur.capturing = 1'b0;
               end
            end else begin
               next_cur.pix_cnt = cur.pix_cnt + 12'h001;
            end
         end
      end
      if (pop) begin
         next_cur.rd_ptr = cur.rd_ptr + 1'b1;
      end
      next_cur.level = cur.level + (ADDR_W+1)'(wr_en) - (ADDR_W+1)'(pop);
      case (cur.st)
         ST_IDLE: begin
            if (i_cmd_valid && cur.cmd_ready) begin
               next_cur.cmd = i_cmd_byte;
               next_cur.arg_cnt = '0;
               if (i_cmd_byte == line_cam_pkg::CMD_STORED) begin
                  next_cur.st = ST_STORE;
                  next_cur.capturing = 1'b1;
                  next_cur.frames_done = '0;
                  next_cur.in_frame = 1'b0;
               end else if (i_cmd_byte == line_cam_pkg::CMD_STREAM) begin
                  next_cur.st = ST_STREAM;
                  next_cur.capturing = 1'b1;
                  next_cur.stop_req = 1'b0;
                  next_cur.stop_frame = 1'b0;
                  next_cur.in_frame = 1'b0;
               end else if (i_cmd_byte == line_cam_pkg::CMD_SERIAL) begin
                  next_cur.qshift = SERIAL_NUMBER;
                  next_cur.qcnt = '0;
                  next_cur.st = ST_QUERY;
               end else if (i_cmd_byte == line_cam_pkg::CMD_SIGNATURE) begin
                  next_cur.qshift = SIGNATURE;
                  next_cur.qcnt = '0;
                  next_cur.st = ST_QUERY;
               end else if (i_cmd_byte == line_cam_pkg::CMD_SET_COUNT
                  || i_cmd_byte == line_cam_pkg::CMD_SET_DUMMY) begin
                  next_cur.st = ST_ARGS;
               end else begin
                  next_cur.one_byte = line_cam_pkg::REPLY_NACK;
                  next_cur.st = ST_BYTE;
               end
            end else begin
               next_cur.cmd_ready = 1'b1;
            end
         end
         ST_ARGS: begin
            next_cur.cmd_ready = 1'b1;
            if (i_cmd_valid && cur.cmd_ready) begin
               next_cur.arg = {cur.arg[23:0], i_cmd_byte};
               next_cur.arg_cnt = cur.arg_cnt + 2'h1;
               if (cur.cmd == line_cam_pkg::CMD_SET_DUMMY) begin
                  next_cur.cmd_ready = 1'b0;
                  next_cur.st = ST_BYTE;
                  if (i_cmd_byte > 8'h01) begin
                     next_cur.one_byte = line_cam_pkg::REPLY_NACK;
                  end else begin
                     next_cur.dummy_en = i_cmd_byte[0];
                     next_cur.one_byte = line_cam_pkg::REPLY_ACK;
                     if (i_cmd_byte[0] && cur.frames_set > line_cam_pkg::MAX_FRAMES_DUMMY) begin
                        next_cur.frames_set = line_cam_pkg::MAX_FRAMES_DUMMY;
                     end
                  end
               end else if (cur.arg_cnt == line_cam_pkg::COUNT_BYTES_LAST) begin
                  next_cur.cmd_ready = 1'b0;
                  next_cur.st = ST_BYTE;
                  if ({cur.arg[23:0], i_cmd_byte} == 32'h0
                     || {cur.arg[23:0], i_cmd_byte} > {19'h0, cur.dummy_en ? line_cam_pkg::MAX_FRAMES_DUMMY
                     : line_cam_pkg::MAX_FRAMES}) begin
                     next_cur.one_byte = line_cam_pkg::REPLY_NACK;
                  end else begin
                     next_cur.frames_set = {cur.arg[4:0], i_cmd_byte};
                     next_cur.one_byte = line_cam_pkg::REPLY_ACK;
                  end
               end
            end
         end
         ST_STORE: begin
            // no command taken until the stored frames are sent
         end
         ST_DRAIN: begin
            if (cur.level == '0 && !cur.capturing && !ser_valid && !cur.out_valid) begin
               next_cur.st = ST_IDLE;
            end
         end
         ST_STREAM: begin
            // other bytes are taken and dropped while streaming
            next_cur.cmd_ready = !cur.stop_req;
            if (i_cmd_valid && cur.cmd_ready && i_cmd_byte == line_cam_pkg::CMD_STOP) begin
               next_cur.stop_req = 1'b1;
               next_cur.cmd_ready = 1'b0;
            end
            if (cur.stop_req && !cur.capturing) begin
               next_cur.st = ST_DRAIN;
            end
         end
         ST_QUERY: begin
            if (byte_take) begin
               next_cur.qshift = {cur.qshift[55:0], 8'h00};
               next_cur.qcnt = cur.qcnt + 3'h1;
               if (cur.qcnt == line_cam_pkg::QUERY_BYTES_LAST) begin
                  next_cur.st = ST_IDLE;
               end
            end
         end
         ST_BYTE: begin
            if (byte_take) begin
               next_cur.st = ST_IDLE;
            end
         end
         default: begin
            next_cur.capturing = 1'b0;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (wr_en) begin
         mem[cur.wr_ptr] <= i_pix;
      end
   end
   assign rd_word = mem[cur.rd_ptr];

   reply_serializer u_ser (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_word_valid(rd_valid),
      .i_word(rd_word),
      .o_word_ready(word_ready),
      .o_byte_valid(ser_valid),
      .o_byte(ser_byte),
      .i_byte_ready(out_take)
   );

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         cur <= '0;
         cur.st <= ST_IDLE;
         cur.frames_set <= line_cam_pkg::DEFAULT_FRAMES;
      end else begin
         cur <= next_cur;
      end
   end

   assign o_cmd_ready = cur.cmd_ready;
   assign o_reply_valid = cur.out_valid;
   assign o_reply_byte = cur.out_byte;
   assign o_capture_active = cur.capturing;
   assign o_error = cur.error;

   sequence stored_done_s;
      cur.st == ST_STORE && cur.capturing && !next_cur.capturing && !next_cur.error;
   endsequence
   auto_stop_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      stored_done_s |=> cur.st == ST_DRAIN && !cur.capturing) else $error("stored capture did not stop");
   drain_blocks_cmd_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (cur.st == ST_DRAIN || cur.st == ST_STORE) |-> !o_cmd_ready) else $error("command taken during drain");
   store_start_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (cur.st == ST_IDLE && i_cmd_valid && o_cmd_ready && i_cmd_byte == line_cam_pkg::CMD_STORED)
      |=> cur.st == ST_STORE && cur.capturing) else $error("stored capture not started");
   stream_start_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (cur.st == ST_IDLE && i_cmd_valid && o_cmd_ready && i_cmd_byte == line_cam_pkg::CMD_STREAM)
      |=> cur.st == ST_STREAM && cur.capturing) else $error("streaming not started");
   overflow_err_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (cur.capturing && cur.in_frame && i_pix_valid && cur.level == MEM_WORDS)
      |=> o_error && !o_capture_active) else $error("overflow not flagged");
   error_sticks_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      o_error |=> o_error) else $error("error cleared without reset");
   nack_unknown_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (cur.st == ST_IDLE && i_cmd_valid && o_cmd_ready && i_cmd_byte == 8'h00)
      |=> cur.one_byte == line_cam_pkg::REPLY_NACK) else $error("unknown command not refused");
   dummy_default_a: assert property (@(posedge i_clk) $rose(i_nrst) |-> !cur.dummy_en)
      else $error("dummy pixels not off after reset");
endmodule : line_camera_acquisition_cmds

// ==== tb/usb_bridge_model.sv ====
/*
 * Behavioural USB FIFO bridge: sends host command bytes and collects reply bytes.
 * Assumes the handler's ready/valid byte streams, all on one clock.
 */
`timescale 1ns/10ps
module usb_bridge_model (
   input wire logic i_clk,
   input wire logic i_stall,
   output logic o_cmd_valid,
   output logic [7:0] o_cmd_byte,
   input wire logic i_cmd_ready,
   input wire logic i_reply_valid,
   input wire logic [7:0] i_reply_byte,
   output logic o_reply_ready
);
   logic [7:0] rx[$];
   initial begin
      o_cmd_valid = 1'b0;
      o_cmd_byte = 8'h00;
   end
   // a slow host is only simulated when the bench asks for it
   always @(negedge i_clk) o_reply_ready <= !i_stall;
   always @(posedge i_clk) begin
      if (i_reply_valid && o_reply_ready) begin
         rx.push_back(i_reply_byte);
      end
   end
   // byte held until taken; afterwards the line shows its inverse
   task send(input logic [7:0] b);
      @(negedge i_clk);
      o_cmd_valid = 1'b1;
      o_cmd_byte = b;
      @(posedge i_clk);
      while (!i_cmd_ready) @(posedge i_clk);
      @(negedge i_clk);
      o_cmd_valid = 1'b0;
      o_cmd_byte = ~b;
   endtask : send
endmodule : usb_bridge_model

// ==== tb/line_camera_acquisition_cmds_test.sv ====
/*
 * Self-checking bench for the acquisition command handler.
 * Assumes the bridge model beside it and the handler's package.
 */
`timescale 1ns/10ps
module line_camera_acquisition_cmds_test;
   localparam logic [63:0] SERIAL = 64'h0123_4567_89ab_cdef; // arbitrary value
   localparam logic [63:0] SIG = 64'hfedc_ba98_7654_3210; // arbitrary value
   localparam int PIX = int'(line_cam_pkg::PIX_ACTIVE);
   logic i_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic stall = 1'b0;
   logic i_frame_start = 1'b0;
   logic i_pix_valid = 1'b0;
   logic [15:0] i_pix = 16'h0000;
   logic cmd_valid, cmd_ready, reply_valid, reply_ready, capture_active, error;
   logic [7:0] cmd_byte, reply_byte;
   int n_errors = 0;
   int compares = 0;
   always #5 i_clk = ~i_clk;
   line_camera_acquisition_cmds #(.ADDR_W(14), .SERIAL_NUMBER(SERIAL), .SIGNATURE(SIG)) DUT (
      .i_clk(i_clk), .i_nrst(i_nrst), .i_cmd_valid(cmd_valid), .i_cmd_byte(cmd_byte),
      .o_cmd_ready(cmd_ready), .o_reply_valid(reply_valid), .o_reply_byte(reply_byte),
      .i_reply_ready(reply_ready), .i_frame_start(i_frame_start), .i_pix_valid(i_pix_valid),
      .i_pix(i_pix), .o_capture_active(capture_active), .o_error(error));
   usb_bridge_model bridge (
      .i_clk(i_clk), .i_stall(stall), .o_cmd_valid(cmd_valid), .o_cmd_byte(cmd_byte),
      .i_cmd_ready(cmd_ready), .i_reply_valid(reply_valid), .i_reply_byte(reply_byte),
      .o_reply_ready(reply_ready));
   task check(input logic [63:0] seen, input logic [63:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task give_verdict;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : give_verdict
   // next reply byte, waiting a bounded time for it
   task want(input logic [7:0] b);
      int t;
      t = 0;
      while (bridge.rx.size() == 0 && t < 20000) begin
         @(posedge i_clk);
         t++;
      end
      check(bridge.rx.size() != 0 ? bridge.rx.pop_front() : 8'hxx, b);
   endtask : want
   task want64(input logic [63:0] v);
      for (int i = 7; i >= 0; i--) want(v[i*8+:8]);
   endtask : want64
   function automatic logic [15:0] pix_of(input int f, input int k);
      return 16'(32'h8000 + f * 32'h1111 + k * 3);
   endfunction : pix_of
   task frame(input int f, input int n);
      @(negedge i_clk);
      i_frame_start = 1'b1;
      @(negedge i_clk);
      i_frame_start = 1'b0;
      for (int k = 0; k < n; k++) begin
         i_pix_valid = 1'b1;
         i_pix = pix_of(f, k);
         @(negedge i_clk);
      end
      i_pix_valid = 1'b0;
   endtask : frame
   task want_frame(input int f, input int n);
      logic [15:0] p;
      for (int k = 0; k < n; k++) begin
         p = pix_of(f, k);
         want(p[15:8]);
         want(p[7:0]);
      end
   endtask : want_frame
   task set_count(input logic [31:0] v, input logic [7:0] r);
      bridge.send(line_cam_pkg::CMD_SET_COUNT);
      for (int i = 3; i >= 0; i--) bridge.send(v[i*8+:8]);
      want(r);
   endtask : set_count
   task set_dummy(input logic [7:0] v, input logic [7:0] r);
      bridge.send(line_cam_pkg::CMD_SET_DUMMY);
      bridge.send(v);
      want(r);
   endtask : set_dummy
   task t_reset;
      @(negedge i_clk);
      i_nrst = 1'b0;
      repeat (2) @(negedge i_clk);
      i_nrst = 1'b1;
      check(reply_valid, 1'b0);
      check(capture_active, 1'b0);
      check(error, 1'b0);
      bridge.rx.delete();
   endtask : t_reset
   task t_queries;
      bridge.send(line_cam_pkg::CMD_SERIAL);
      want64(SERIAL);
      bridge.send(line_cam_pkg::CMD_SIGNATURE);
      want64(SIG);
      bridge.send(8'h00);
      want(line_cam_pkg::REPLY_NACK);
   endtask : t_queries
   task t_config;
      set_count(32'h0000_11f8, line_cam_pkg::REPLY_NACK);
      set_count(32'h0000_0000, line_cam_pkg::REPLY_NACK);
      set_count(32'h0000_11f7, line_cam_pkg::REPLY_ACK);
      set_dummy(8'h02, line_cam_pkg::REPLY_NACK);
      set_dummy(8'h01, line_cam_pkg::REPLY_ACK);
      set_count(32'h0000_11be, line_cam_pkg::REPLY_NACK);
      set_count(32'h0000_11bd, line_cam_pkg::REPLY_ACK);
      set_dummy(8'h00, line_cam_pkg::REPLY_ACK);
      set_count(32'h0000_0002, line_cam_pkg::REPLY_ACK);
   endtask : t_config
   task t_stored;
      bridge.send(line_cam_pkg::CMD_STORED);
      repeat (2) @(negedge i_clk);
      check(capture_active, 1'b1);
      check(cmd_ready, 1'b0);
      frame(0, PIX);
      frame(1, PIX);
      repeat (4) @(negedge i_clk);
      check(capture_active, 1'b0);
      check(bridge.rx.size() > 0, 1'b1);
      stall = 1'b1;
      repeat (200) @(negedge i_clk);
      check(cmd_ready, 1'b0);
      stall = 1'b0;
      want_frame(0, PIX);
      want_frame(1, PIX);
      bridge.send(line_cam_pkg::CMD_SERIAL);
      want64(SERIAL);
   endtask : t_stored
   task t_dummy;
      set_dummy(8'h01, line_cam_pkg::REPLY_ACK);
      set_count(32'h0000_0001, line_cam_pkg::REPLY_ACK);
      bridge.send(line_cam_pkg::CMD_STORED);
      repeat (2) @(negedge i_clk);
      frame(2, int'(line_cam_pkg::PIX_DUMMY));
      want_frame(2, int'(line_cam_pkg::PIX_DUMMY));
      set_dummy(8'h00, line_cam_pkg::REPLY_ACK);
   endtask : t_dummy
   task t_stream;
      bridge.send(line_cam_pkg::CMD_STREAM);
      repeat (2) @(negedge i_clk);
      check(capture_active, 1'b1);
      bridge.send(line_cam_pkg::CMD_SERIAL);
      frame(3, PIX);
      check(bridge.rx.size() > 0, 1'b1);
      frame(4, PIX);
      check(capture_active, 1'b1);
      bridge.send(line_cam_pkg::CMD_STOP);
      check(capture_active, 1'b1);
      frame(5, PIX);
      repeat (4) @(negedge i_clk);
      check(capture_active, 1'b0);
      frame(6, PIX);
      want_frame(3, PIX);
      want_frame(4, PIX);
      want_frame(5, PIX);
      repeat (300) @(negedge i_clk);
      check(bridge.rx.size(), 0);
   endtask : t_stream
   task t_overflow;
      stall = 1'b1;
      bridge.send(line_cam_pkg::CMD_STREAM);
      for (int f = 0; f < 5; f++) frame(f, PIX);
      check(error, 1'b1);
      check(capture_active, 1'b0);
      stall = 1'b0;
      t_reset();
   endtask : t_overflow
   initial begin
      // the scenarios need about 75000 cycles
      #900_000;
      n_errors++;
      give_verdict();
   end
   initial begin
      t_reset();
      t_queries();
      t_config();
      t_stored();
      t_dummy();
      t_stream();
      t_overflow();
      give_verdict();
   end
endmodule : line_camera_acquisition_cmds_test
